// *** rtl/tsm_monitor.sv ***
// Purpose: SMBus slave, registers and conversion control of the monitor
// Assumes: Analog converter runs on adc_clk_i and returns raw readings
// Notes:   SCL is sampled as a plain input; no clock stretching
`timescale 1ns/10ps
module tsm_monitor #(
  parameter logic [6:0]  SLAVE_ADDR      = 7'h2A, // Value is arbitrary
  parameter int unsigned CONV_CYC        = tsm_pkg::CONV_CYC,
  parameter int unsigned SLOW_PERIOD_CYC = tsm_pkg::SLOW_PERIOD_CYC
) (
  // System clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // SMBus pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  // Open-drain alert pin
  output logic                      alert_o,
  output logic                      alert_oe_o,
  // Analog converter link
  input  wire logic                 adc_clk_i,
  output logic                      adc_start_o,
  input  wire logic                 adc_valid_i,
  input  wire tsm_pkg::tsm_raw_type adc_result_i,
  input  wire logic                 diode_open_i
);

  tsm_pkg::tsm_bus_state_type st_reg, st_next;
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic        drv_reg, drv_next;
  logic        rd_reg, rd_next;
  logic        ara_reg, ara_next;
  logic        idx_reg, idx_next;
  logic [1:0]  wcnt_reg, wcnt_next;
  logic [7:0]  ptr_reg;
  logic        scl_s, sda_s, scl_q, sda_q, open_s;
  logic [7:0]  high1_reg, low1_reg, high2_reg, low2_reg;
  logic [7:0]  cfg_reg, rate_reg;
  logic signed [7:0] temp1_reg, temp2_reg, fmt1_w, fmt2_w;
  tsm_pkg::tsm_flags_type flags_reg, live_reg, set_w, cmp_w;
  logic        alert_reg, busy_reg, shot_reg, started_reg, got_reg;
  logic [31:0] conv_cnt_reg, rate_cnt_reg;
  logic        req_tgl_reg, done_s, done_q;
  tsm_pkg::tsm_raw_type raw_sys_reg, raw_adc_reg;
  logic        req_s, req_q, adc_start_reg, done_tgl_reg;

  // Pin and link synchronisers
  tsm_sync3 #(.W(2), .RST(2'h3)) u_sync_bus (
    .clk_i  (clk_sys_i),
    .nrst_i (nrst_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    ({scl_s, sda_s})
  );
  tsm_sync3 #(.W(2), .RST(2'h0)) u_sync_sys (
    .clk_i  (clk_sys_i),
    .nrst_i (nrst_i),
    .d_i    ({diode_open_i, done_tgl_reg}),
    .q_o    ({open_s, done_s})
  );
  tsm_sync3 #(.W(1), .RST(1'h0)) u_sync_adc (
    .clk_i  (adc_clk_i),
    .nrst_i (nrst_i),
    .d_i    (req_tgl_reg),
    .q_o    (req_s)
  );

  // Bus events on the filtered levels
  wire scl_rise_w = scl_s && !scl_q;
  wire scl_fall_w = !scl_s && scl_q;
  wire start_w    = scl_s && scl_q && sda_q && !sda_s;
  wire stop_w     = scl_s && scl_q && !sda_q && sda_s;
  wire bus_evt_w  = !start_w && !stop_w;
  wire byte_end_w = scl_fall_w && (bit_reg == 4'h8) && bus_evt_w;

  // Address decode: own address, or alert response while alerting
  wire ara_hit_w  = (sh_reg[7:1] == tsm_pkg::ARA_ADDR) && sh_reg[0] &&
                    alert_reg;
  wire addr_ok_w  = (sh_reg[7:1] == SLAVE_ADDR) || ara_hit_w;
  wire in_rx_w    = (st_reg == tsm_pkg::BS_RX) && byte_end_w;
  wire cmd_load_w = in_rx_w && !idx_reg;
  // A refused third byte must not land in a register
  wire wr_pulse_w = in_rx_w && idx_reg && (wcnt_reg == 2'h1);
  wire tx_done_w  = (st_reg == tsm_pkg::BS_ACKT) && scl_rise_w && bus_evt_w;
  wire ara_clr_w  = tx_done_w && ara_reg;
  wire stat_clr_w = tx_done_w && !ara_reg &&
                    (ptr_reg == tsm_pkg::CMD_RD_STAT);
  // Send byte is a lone command byte closed by a stop
  wire oneshot_w  = stop_w && !rd_reg && (wcnt_reg == 2'h1) &&
                    (ptr_reg == tsm_pkg::CMD_ONE_SHOT);

  // Read selection; unknown pointers read zero
  wire [7:0] stat_w = {busy_reg, flags_reg, 2'h0};
  wire [7:0] reg_rd_w =
    (ptr_reg == tsm_pkg::CMD_RD_TEMP2) ? temp2_reg :
    (ptr_reg == tsm_pkg::CMD_RD_TEMP1) ? temp1_reg :
    (ptr_reg == tsm_pkg::CMD_RD_STAT)  ? stat_w    :
    (ptr_reg == tsm_pkg::CMD_RD_CFG)   ? cfg_reg   :
    (ptr_reg == tsm_pkg::CMD_RD_RATE)  ? rate_reg  :
    (ptr_reg == tsm_pkg::CMD_RD_HIGH2) ? high2_reg :
    (ptr_reg == tsm_pkg::CMD_RD_LOW2)  ? low2_reg  :
    (ptr_reg == tsm_pkg::CMD_RD_HIGH1) ? high1_reg :
    (ptr_reg == tsm_pkg::CMD_RD_LOW1)  ? low1_reg  : 8'h00;
  // Alert response returns our own address
  wire [7:0] tx_byte_w = ara_reg ? {SLAVE_ADDR, 1'b0} : reg_rd_w;

  // Byte engine: bits taken on SCL rise, driven after SCL fall
  always_comb begin
    st_next   = st_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    drv_next  = drv_reg;
    rd_next   = rd_reg;
    ara_next  = ara_reg;
    idx_next  = idx_reg;
    wcnt_next = wcnt_reg;
    if (start_w) begin
      st_next   = tsm_pkg::BS_ADDR;
      bit_next  = 4'h0;
      drv_next  = 1'b0;
      rd_next   = 1'b0;
      ara_next  = 1'b0;
      idx_next  = 1'b0;
      wcnt_next = 2'h0;
    end else if (stop_w) begin
      st_next  = tsm_pkg::BS_IDLE;
      drv_next = 1'b0;
    end else begin
      case (st_reg)
        tsm_pkg::BS_ADDR: begin
          if (scl_rise_w) begin
            sh_next  = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (byte_end_w) begin
            if (addr_ok_w) begin
              st_next  = tsm_pkg::BS_ACKA;
              drv_next = 1'b1;
              rd_next  = sh_reg[0];
              ara_next = ara_hit_w;
            end else begin
              st_next = tsm_pkg::BS_IDLE;
            end
          end
        end
        tsm_pkg::BS_ACKA: begin
          if (scl_fall_w) begin
            bit_next = 4'h0;
            if (rd_reg) begin
              st_next  = tsm_pkg::BS_TX;
              sh_next  = tx_byte_w;
              drv_next = !tx_byte_w[7];
            end else begin
              st_next  = tsm_pkg::BS_RX;
              drv_next = 1'b0;
            end
          end
        end
        tsm_pkg::BS_RX: begin
          if (scl_rise_w) begin
            sh_next  = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (byte_end_w) begin
            // A third byte is refused: no block protocols
            st_next   = (wcnt_reg == 2'h2) ? tsm_pkg::BS_IDLE :
                                             tsm_pkg::BS_ACKR;
            drv_next  = (wcnt_reg != 2'h2);
            idx_next  = 1'b1;
            wcnt_next = (wcnt_reg == 2'h2) ? 2'h2 : wcnt_reg + 2'h1;
          end
        end
        tsm_pkg::BS_ACKR: begin
          if (scl_fall_w) begin
            st_next  = tsm_pkg::BS_RX;
            drv_next = 1'b0;
            bit_next = 4'h0;
          end
        end
        tsm_pkg::BS_TX: begin
          if (scl_rise_w) begin
            bit_next = bit_reg + 4'h1;
            // Released a one but line is low: arbitration lost
            if (!drv_reg && !sda_s) begin
              st_next = tsm_pkg::BS_IDLE;
            end
          end else if (scl_fall_w) begin
            if (bit_reg == 4'h8) begin
              st_next  = tsm_pkg::BS_ACKT;
              drv_next = 1'b0;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0};
              drv_next = !sh_reg[6];
            end
          end
        end
        tsm_pkg::BS_ACKT: begin
          if (scl_rise_w && sda_s) begin
            st_next = tsm_pkg::BS_IDLE;
          end else if (scl_fall_w) begin
            st_next  = tsm_pkg::BS_TX;
            sh_next  = tx_byte_w;
            drv_next = !tx_byte_w[7];
            bit_next = 4'h0;
          end
        end
        default: begin
          st_next = tsm_pkg::BS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg   <= tsm_pkg::BS_IDLE;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      drv_reg  <= 1'b0;
      rd_reg   <= 1'b0;
      ara_reg  <= 1'b0;
      idx_reg  <= 1'b0;
      wcnt_reg <= 2'h0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      st_reg   <= st_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      drv_reg  <= drv_next;
      rd_reg   <= rd_next;
      ara_reg  <= ara_next;
      idx_reg  <= idx_next;
      wcnt_reg <= wcnt_next;
      scl_q    <= scl_s;
      sda_q    <= sda_s;
    end
  end

  // Register writes keyed by the pointer; kept in standby
  wire wr_cfg_w   = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_CFG);
  wire wr_rate_w  = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_RATE);
  wire wr_high2_w = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_HIGH2);
  wire wr_low2_w  = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_LOW2);
  wire wr_high1_w = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_HIGH1);
  wire wr_low1_w  = wr_pulse_w && (ptr_reg == tsm_pkg::CMD_WR_LOW1);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_reg   <= tsm_pkg::PTR_RST;
      cfg_reg   <= tsm_pkg::CONFIG_RST;
      rate_reg  <= tsm_pkg::RATE_RST;
      high1_reg <= tsm_pkg::HIGH_LIMIT_RST;
      high2_reg <= tsm_pkg::HIGH_LIMIT_RST;
      low1_reg  <= tsm_pkg::LOW_LIMIT_RST;
      low2_reg  <= tsm_pkg::LOW_LIMIT_RST;
    end else begin
      ptr_reg   <= cmd_load_w ? sh_reg : ptr_reg;
      cfg_reg   <= wr_cfg_w   ? sh_reg : cfg_reg;
      rate_reg  <= wr_rate_w  ? sh_reg : rate_reg;
      high1_reg <= wr_high1_w ? sh_reg : high1_reg;
      high2_reg <= wr_high2_w ? sh_reg : high2_reg;
      low1_reg  <= wr_low1_w  ? sh_reg : low1_reg;
      low2_reg  <= wr_low2_w  ? sh_reg : low2_reg;
    end
  end

  // Conversion sequencing; codes above 7 run at the fastest rate
  wire [2:0]  rate_eff_w = (rate_reg > 8'(tsm_pkg::RATE_MAX)) ?
                           tsm_pkg::RATE_MAX : rate_reg[2:0];
  wire [31:0] period_w   = 32'(SLOW_PERIOD_CYC) >> rate_eff_w;
  wire standby_w  = cfg_reg[tsm_pkg::CFG_STOP];
  wire auto_due_w = !standby_w && (rate_cnt_reg >= period_w - 32'h1);
  // One-shot while busy is ignored
  wire go_w       = !busy_reg && (oneshot_w || auto_due_w);
  wire conv_end_w = busy_reg && (conv_cnt_reg == 32'(CONV_CYC) - 32'h1);
  wire abort_w    = busy_reg && standby_w && !shot_reg;
  wire publish_w  = conv_end_w && got_reg;
  wire done_evt_w = done_s ^ done_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_reg     <= 1'b0;
      shot_reg     <= 1'b0;
      started_reg  <= 1'b0;
      conv_cnt_reg <= 32'h0;
      rate_cnt_reg <= 32'h0;
      req_tgl_reg  <= 1'b0;
    end else begin
      busy_reg     <= go_w | (busy_reg & !conv_end_w & !abort_w);
      shot_reg     <= go_w ? oneshot_w : shot_reg;
      started_reg  <= started_reg | go_w;
      conv_cnt_reg <= go_w ? 32'h0 : conv_cnt_reg + {31'h0, busy_reg};
      rate_cnt_reg <= go_w ? 32'h0 :
                      rate_cnt_reg + {31'h0, !standby_w && !auto_due_w};
      req_tgl_reg  <= req_tgl_reg ^ go_w;
    end
  end

  // Results arrive as a bundle under the done toggle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q      <= 1'b0;
      got_reg     <= 1'b0;
      raw_sys_reg <= '0;
      temp1_reg   <= tsm_pkg::TEMP_RST;
      temp2_reg   <= tsm_pkg::TEMP_RST;
    end else begin
      done_q      <= done_s;
      got_reg     <= done_evt_w | (got_reg & !go_w);
      raw_sys_reg <= done_evt_w ? raw_adc_reg : raw_sys_reg;
      temp1_reg   <= publish_w ? fmt1_w : temp1_reg;
      temp2_reg   <= publish_w ? fmt2_w : temp2_reg;
    end
  end

  tsm_temp_fmt u_fmt1 (
    .raw_i  (raw_sys_reg.ch1),
    .temp_o (fmt1_w)
  );
  tsm_temp_fmt u_fmt2 (
    .raw_i  (raw_sys_reg.ch2),
    .temp_o (fmt2_w)
  );

  // Limits count as reached on equality
  assign cmp_w.high2 = fmt2_w >= $signed(high2_reg);
  assign cmp_w.low2  = fmt2_w <= $signed(low2_reg);
  assign cmp_w.high1 = fmt1_w >= $signed(high1_reg);
  assign cmp_w.low1  = fmt1_w <= $signed(low1_reg);
  assign cmp_w.open  = open_s;
  assign set_w.high2 = publish_w && cmp_w.high2;
  assign set_w.low2  = publish_w && cmp_w.low2;
  assign set_w.high1 = publish_w && cmp_w.high1;
  assign set_w.low1  = publish_w && cmp_w.low1;
  assign set_w.open  = go_w && cmp_w.open;

  // Set beats clear; a persisting condition survives the read
  wire [4:0] flags_next = stat_clr_w ? (live_reg | set_w) :
                                       (flags_reg | set_w);
  wire alert_set_w = !cfg_reg[tsm_pkg::CFG_MASK] && (set_w != 5'h00);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= '0;
      live_reg  <= '0;
      alert_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      live_reg  <= {publish_w ? cmp_w[4:1] : live_reg[4:1],
                    go_w ? cmp_w.open : live_reg.open};
      alert_reg <= alert_set_w | (alert_reg & !ara_clr_w);
    end
  end

  // Converter-side domain: start pulse out, readings captured in
  always_ff @(posedge adc_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_q         <= 1'b0;
      adc_start_reg <= 1'b0;
      raw_adc_reg   <= '0;
      done_tgl_reg  <= 1'b0;
    end else begin
      req_q         <= req_s;
      adc_start_reg <= req_s ^ req_q;
      raw_adc_reg   <= adc_valid_i ? adc_result_i : raw_adc_reg;
      done_tgl_reg  <= done_tgl_reg ^ adc_valid_i;
    end
  end

  assign sda_o       = 1'b0;
  assign sda_oe_o    = drv_reg;
  assign alert_o     = 1'b0;
  assign alert_oe_o  = alert_reg;
  assign adc_start_o = adc_start_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_busy_bit_shown: assert property (
    (ptr_reg == tsm_pkg::CMD_RD_STAT) && !ara_reg |->
    tx_byte_w[tsm_pkg::ST_BUSY] == busy_reg)
    else $error("status bit 7 differs from busy");
  a_oneshot_runs: assert property (
    oneshot_w && !busy_reg |=> busy_reg && shot_reg)
    else $error("one-shot did not start");
  a_conv_length: assert property (
    $fell(busy_reg) |-> $past(conv_end_w) || $past(abort_w))
    else $error("conversion ended early");
  a_standby_quiet: assert property (
    standby_w && !busy_reg && !oneshot_w |=> !busy_reg)
    else $error("conversion began in standby");
  a_no_open_early: assert property (
    !started_reg |-> !flags_reg.open)
    else $error("open flag before first conversion");
  a_alert_latched: assert property (
    alert_reg && !ara_clr_w |=> alert_reg)
    else $error("alert dropped without response read");
  a_alert_on_limit: assert property (
    publish_w && cmp_w.high1 && !cfg_reg[tsm_pkg::CFG_MASK] |=>
    alert_reg && flags_reg.high1)
    else $error("high limit reached without alert");
  a_status_clear: assert property (
    stat_clr_w && set_w == 5'h00 |=> flags_reg == $past(live_reg))
    else $error("status not cleared");
  a_ptr_load: assert property (
    cmd_load_w |=> ptr_reg == $past(sh_reg))
    else $error("command byte not loaded");
  a_addr_ack: assert property (
    (st_reg == tsm_pkg::BS_ADDR) && byte_end_w &&
    (sh_reg[7:1] == SLAVE_ADDR) |=> sda_oe_o)
    else $error("own address not acknowledged");
  a_temp_range: assert property (
    temp1_reg >= tsm_pkg::TEMP_MIN && temp2_reg >= tsm_pkg::TEMP_MIN)
    else $error("reading below clamp");

  c_oneshot_standby: cover property (standby_w && oneshot_w && !busy_reg);
  c_ara_clear: cover property (ara_clr_w);
  c_status_read: cover property (stat_clr_w);
  c_limit_write: cover property (wr_high1_w ##[1:1000] publish_w);

endmodule : tsm_monitor

// *** rtl/tsm_pkg.sv ***
// Purpose: Shared constants and types of the remote temperature monitor
// Assumes: 10 MHz system clock, raw readings with two fraction bits
// Notes:   Command codes double as register pointer values
package tsm_pkg;

  localparam int SYS_CLK_HZ      = 10_000_000;
  localparam int CONV_TIME_MS    = 125;
  localparam int CONV_CYC        = CONV_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int SLOW_PERIOD_MS  = 16_000;
  localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_MS * (SYS_CLK_HZ / 1000);

  localparam int RAW_W    = 11;
  localparam int RAW_FRAC = 2;
  localparam logic signed [RAW_W:0] RAW_HALF = 12'sh002;

  localparam logic [6:0] ARA_ADDR = 7'h0C;

  localparam logic [7:0] CMD_RD_TEMP2 = 8'h00;
  localparam logic [7:0] CMD_RD_TEMP1 = 8'h01;
  localparam logic [7:0] CMD_RD_STAT  = 8'h02;
  localparam logic [7:0] CMD_RD_CFG   = 8'h03;
  localparam logic [7:0] CMD_RD_RATE  = 8'h04;
  localparam logic [7:0] CMD_RD_HIGH2 = 8'h05;
  localparam logic [7:0] CMD_RD_LOW2  = 8'h06;
  localparam logic [7:0] CMD_RD_HIGH1 = 8'h07;
  localparam logic [7:0] CMD_RD_LOW1  = 8'h08;
  localparam logic [7:0] CMD_WR_CFG   = 8'h09;
  localparam logic [7:0] CMD_WR_RATE  = 8'h0A;
  localparam logic [7:0] CMD_WR_HIGH2 = 8'h0B;
  localparam logic [7:0] CMD_WR_LOW2  = 8'h0C;
  localparam logic [7:0] CMD_WR_HIGH1 = 8'h0D;
  localparam logic [7:0] CMD_WR_LOW1  = 8'h0E;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;

  localparam logic [7:0] HIGH_LIMIT_RST = 8'h7F;
  localparam logic [7:0] LOW_LIMIT_RST  = 8'hC9;
  localparam logic [7:0] CONFIG_RST     = 8'h12;
  localparam logic [7:0] RATE_RST       = 8'h02;
  localparam logic [7:0] PTR_RST        = 8'h00;
  localparam logic [7:0] TEMP_RST       = 8'h00;
  localparam logic [2:0] RATE_MAX       = 3'h7;

  localparam logic signed [7:0] TEMP_MAX = 8'sh7F;
  localparam logic signed [7:0] TEMP_MIN = 8'shBF;

  localparam int ST_BUSY  = 7;
  localparam int CFG_MASK = 7;
  localparam int CFG_STOP = 6;

  typedef struct packed {
    logic signed [RAW_W-1:0] ch2;
    logic signed [RAW_W-1:0] ch1;
  } tsm_raw_type;

  // Flag order matches status bits 6 down to 2
  typedef struct packed {
    logic high2;
    logic low2;
    logic high1;
    logic low1;
    logic open;
  } tsm_flags_type;

  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_ADDR = 7'h02,
    BS_ACKA = 7'h04,
    BS_RX   = 7'h08,
    BS_ACKR = 7'h10,
    BS_TX   = 7'h20,
    BS_ACKT = 7'h40
  } tsm_bus_state_type;

endpackage : tsm_pkg

// *** rtl/tsm_sync3.sv ***
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/10ps
module tsm_sync3 #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  wire  [W-1:0] q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q_reg  <= RST;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : tsm_sync3

// *** rtl/tsm_temp_fmt.sv ***
// Purpose: Round and saturate one raw reading to an 8-bit code
// Assumes: Raw reading is signed with two fraction bits
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/10ps
module tsm_temp_fmt (
  // Raw reading
  input  wire logic signed [tsm_pkg::RAW_W-1:0] raw_i,
  // Whole-degree code
  output logic signed      [7:0]                temp_o
);

  localparam int IW = tsm_pkg::RAW_W + 1 - tsm_pkg::RAW_FRAC;

  logic signed [tsm_pkg::RAW_W:0] sum_w;
  logic signed [IW-1:0]           int_w;
  logic                           over_w;
  logic                           under_w;

  // Half degree added before the fraction is dropped
  assign sum_w   = {raw_i[tsm_pkg::RAW_W-1], raw_i} + tsm_pkg::RAW_HALF;
  assign int_w   = sum_w[tsm_pkg::RAW_W:tsm_pkg::RAW_FRAC];
  assign over_w  = int_w > IW'(tsm_pkg::TEMP_MAX);
  assign under_w = int_w < IW'(tsm_pkg::TEMP_MIN);
  // Saturate at both ends; zero passes unchanged
  assign temp_o  = over_w  ? tsm_pkg::TEMP_MAX :
                   under_w ? tsm_pkg::TEMP_MIN : int_w[7:0];

endmodule : tsm_temp_fmt

// *** test/smbus_dual_remote_temp_monitor_tb.sv ***
// Purpose: Bit-banged SMBus host exercising the monitor
// Assumes: Pull-up on SDA, SCL driven by the host only
// Notes:   Shortened conversion time keeps the run brief
`timescale 1ns/10ps
module smbus_dual_remote_temp_monitor_tb;
  localparam logic [6:0] ADR = 7'h2A;
  logic                 clk_sys_i  = 1'b0;
  logic                 nrst_i     = 1'b0;
  logic                 scl        = 1'b1;
  logic                 sda_m      = 1'b1;
  logic                 adc_clk    = 1'b0;
  logic                 diode_open = 1'b1;
  tsm_pkg::tsm_raw_type raw        = '0;
  tsm_pkg::tsm_raw_type result;
  logic                 adc_start, adc_valid, sda_oe, alert_oe;
  logic [7:0]           d;
  int                   n_mismatch  = 0;
  int                   checks_done = 0;
  wire                  sda = sda_m & ~sda_oe;

  tsm_monitor #(.SLAVE_ADDR(ADR), .CONV_CYC(2000),
    .SLOW_PERIOD_CYC(400_000_000)) i_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .alert_o(), .alert_oe_o(alert_oe),
    .adc_clk_i(adc_clk), .adc_start_o(adc_start), .adc_valid_i(adc_valid),
    .adc_result_i(result), .diode_open_i(diode_open));
  tsm_adc_model i_adc (.adc_clk_i(adc_clk), .start_i(adc_start),
    .raw_i(raw), .valid_o(adc_valid), .result_o(result));

  always #50 clk_sys_i = ~clk_sys_i;
  initial begin
    #7;
    forever #24 adc_clk = ~adc_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic bitx(input logic b, output logic r);
    sda_m <= b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask : bitx
  // High first gives START, low first gives STOP
  task automatic cond(input logic first);
    sda_m <= first;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_m <= ~first;
    tick(5);
    scl <= ~first;
    tick(5);
  endtask : cond
  // Host always releases the ninth bit, so reads end in NACK
  task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(1'b1, a);
  endtask : xfer
  // Kind 0 write, 1 read, 2 send, 3 receive
  task automatic txn(input logic [6:0] a, input int k, input logic [7:0] c, v);
    logic       ack;
    logic [7:0] x;
    cond(1'b1);
    xfer({a, k == 3}, x, ack);
    chk("addr ack", {7'h00, ack}, 8'h00);
    if (k != 3) xfer(c, x, ack);
    if (k == 0) xfer(v, x, ack);
    if (k == 1) begin
      cond(1'b1);
      xfer({a, 1'b1}, x, ack);
    end
    if (k == 1 || k == 3) xfer(8'hFF, d, ack);
    cond(1'b0);
  endtask : txn

  initial begin
    tick(6);
    nrst_i <= 1'b1;
    tick(8);
    for (int i = 5; i < 9; i++) begin
      txn(ADR, 1, 8'(i), 8'h00);
      chk("limit", d, i[0] ? 8'h7F : 8'hC9);
    end
    txn(ADR, 1, tsm_pkg::CMD_RD_STAT, 8'h00);
    chk("status por", d, 8'h00);
    txn(ADR, 0, tsm_pkg::CMD_WR_HIGH1, 8'h64);
    txn(ADR, 2, tsm_pkg::CMD_RD_HIGH1, 8'h00);
    txn(ADR, 3, 8'h00, 8'h00);
    chk("receive", d, 8'h64);
    raw <= {11'h6E8, 11'h18E};
    txn(ADR, 2, tsm_pkg::CMD_ONE_SHOT, 8'h00);
    txn(ADR, 1, tsm_pkg::CMD_RD_STAT, 8'h00);
    chk("status busy", d, 8'h84);
    tick(2000);
    txn(ADR, 1, tsm_pkg::CMD_RD_TEMP1, 8'h00);
    chk("temp1", d, 8'h64);
    txn(ADR, 1, tsm_pkg::CMD_RD_TEMP2, 8'h00);
    chk("temp2", d, 8'hBF);
    txn(ADR, 1, tsm_pkg::CMD_RD_STAT, 8'h00);
    chk("status end", d, 8'h34);
    chk("alert on", {7'h00, alert_oe}, 8'h01);
    txn(tsm_pkg::ARA_ADDR, 3, 8'h00, 8'h00);
    chk("alert addr", d, {ADR, 1'b0});
    chk("alert off", {7'h00, alert_oe}, 8'h00);
    txn(ADR, 0, tsm_pkg::CMD_WR_CFG, 8'h40);
    txn(ADR, 1, tsm_pkg::CMD_RD_CFG, 8'h00);
    chk("config", d, 8'h40);
    // Channel one shorted, channel two past full scale, diode closed
    raw <= {11'h200, 11'h000};
    diode_open <= 1'b0;
    txn(ADR, 2, tsm_pkg::CMD_ONE_SHOT, 8'h00);
    tick(2500);
    txn(ADR, 1, tsm_pkg::CMD_RD_TEMP1, 8'h00);
    chk("standby temp", d, 8'h00);
    txn(ADR, 1, tsm_pkg::CMD_RD_TEMP2, 8'h00);
    chk("full scale", d, 8'h7F);
    chk("alert high", {7'h00, alert_oe}, 8'h01);
    txn(ADR, 1, tsm_pkg::CMD_RD_STAT, 8'h00);
    chk("status high", d, 8'h74);
    txn(ADR, 1, tsm_pkg::CMD_RD_STAT, 8'h00);
    chk("status kept", d, 8'h40);
    final_report();
  end

  initial begin
    tick(80000);
    n_mismatch++;
    final_report();
  end
endmodule : smbus_dual_remote_temp_monitor_tb

// *** test/tsm_adc_model.sv ***
// Purpose: Converter stand-in answering each start with one result
// Assumes: Start is a one-cycle pulse on adc_clk_i
// Notes:   Result lines carry the inverse between answers
`timescale 1ns/10ps
module tsm_adc_model (
  // Converter link
  input  wire logic                 adc_clk_i,
  input  wire logic                 start_i,
  input  wire tsm_pkg::tsm_raw_type raw_i,
  output logic                      valid_o,
  output tsm_pkg::tsm_raw_type      result_o
);
  int cnt = 0;
  // Slow answer, yet well inside one conversion
  always @(posedge adc_clk_i) begin
    valid_o  <= (cnt == 1);
    result_o <= (cnt == 1) ? raw_i : ~raw_i;
    cnt      <= start_i ? 12 : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule : tsm_adc_model
